// file: rtl/burst_addr_gen.sv
module burst_addr_gen
  import sram_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               step_en,
  input  wire logic               load,
  input  wire logic [BURST_W-1:0] start,
  input  wire logic               mode_interleaved,
  output logic      [BURST_W-1:0] offset
);

  logic [BURST_W-1:0] base_ff;
  logic [BURST_W-1:0] cnt_ff;
  logic [BURST_W-1:0] nxt_base;
  logic [BURST_W-1:0] nxt_cnt;

  always_comb begin
    nxt_base = base_ff;
    nxt_cnt  = cnt_ff;
    if (step_en) begin
      if (load) begin
        nxt_base = start;
        nxt_cnt  = BURST_CNT_RESET;
      end else begin
        // The two-bit count wraps by itself after four beats.
        nxt_cnt = cnt_ff + BURST_CNT_STEP;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_ff <= BURST_CNT_RESET;
      cnt_ff  <= BURST_CNT_RESET;
    end else begin
      base_ff <= nxt_base;
      cnt_ff  <= nxt_cnt;
    end
  end

  // Offset of the beat being taken at this edge.
  always_comb begin
    if (mode_interleaved) begin
      offset = nxt_base ^ nxt_cnt;
    end else begin
      offset = nxt_base + nxt_cnt;
    end
  end

endmodule

// file: rtl/mem_port_if.sv
interface mem_port_if #(
  parameter int ADDR_W = 19
);
  import sram_pkg::*;

  logic                 wr_en;
  logic [ADDR_W-1:0]    wr_addr;
  logic [WORD_W-1:0]    wr_data;
  logic [LANES-1:0]     wr_bw_n;
  logic [ADDR_W-1:0]    rd_addr;
  logic [WORD_W-1:0]    rd_data;

  modport ctl (
    output wr_en,
    output wr_addr,
    output wr_data,
    output wr_bw_n,
    output rd_addr,
    input  rd_data
  );

  modport mem (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  wr_bw_n,
    input  rd_addr,
    output rd_data
  );
endinterface

// file: rtl/pipelined_sram_io_control.sv
module pipelined_sram_io_control
  import sram_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              chip_select_1_n,
  input  wire logic              chip_select_2,
  input  wire logic              chip_select_3_n,
  input  wire logic              write_enable_n,
  input  wire logic              advance_or_load,
  input  wire logic              clock_qualify_n,
  input  wire logic [LANES-1:0]  byte_write_select_n,
  input  wire logic              output_enable_n,
  input  wire logic              burst_mode,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic      [DATA_W-1:0] dq_oe,
  input  wire logic [LANES-1:0]  parity_lines_in,
  output logic      [LANES-1:0]  parity_lines_out,
  output logic      [LANES-1:0]  parity_lines_oe
);

  if (ADDR_W < BURST_W + 1) begin : g_check
    $error("pipelined_sram_io_control needs ADDR_W of at least 3");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser.

  logic mode_s1_ff;
  logic mode_s2_ff;
  logic nxt_mode_s1;
  logic nxt_mode_s2;

  always_comb begin
    nxt_mode_s1 = burst_mode;
    nxt_mode_s2 = mode_s1_ff;
  end

  // Resetting to interleaved covers a floating strap until it settles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_s1_ff <= MODE_RESET;
      mode_s2_ff <= MODE_RESET;
    end else begin
      mode_s1_ff <= nxt_mode_s1;
      mode_s2_ff <= nxt_mode_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address stage: load or advance, one beat per qualified edge.

  logic                     step_en;
  logic                     selected;
  logic                     load;
  logic [BURST_W-1:0]       burst_offset;
  logic [ADDR_W-1:BURST_W]  hi_ff;
  logic [ADDR_W-1:BURST_W]  nxt_hi;
  op_t                      burst_op_ff;
  op_t                      nxt_burst_op;
  op_t                      op1_ff;
  op_t                      nxt_op1;
  logic [ADDR_W-1:0]        addr1_ff;
  logic [ADDR_W-1:0]        nxt_addr1;
  logic [LANES-1:0]         bw1_ff;
  logic [LANES-1:0]         nxt_bw1;

  assign step_en  = !clock_qualify_n;
  assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign load     = !advance_or_load;

  burst_addr_gen u_burst (
    .clk              (clk),
    .rst              (rst),
    .step_en          (step_en),
    .load             (load),
    .start            (addr[BURST_W-1:0]),
    .mode_interleaved (mode_s2_ff),
    .offset           (burst_offset)
  );

  always_comb begin
    nxt_hi       = hi_ff;
    nxt_burst_op = burst_op_ff;
    nxt_op1      = op1_ff;
    nxt_addr1    = addr1_ff;
    nxt_bw1      = bw1_ff;
    if (step_en) begin
      nxt_bw1 = byte_write_select_n;
      if (load) begin
        nxt_hi = addr[ADDR_W-1:BURST_W];
        if (!selected) begin
          nxt_burst_op = OP_IDLE;
        end else if (write_enable_n) begin
          nxt_burst_op = OP_READ;
        end else begin
          nxt_burst_op = OP_WRITE;
        end
        nxt_op1 = nxt_burst_op;
      end else begin
        // A burst beat keeps the access type latched at the load.
        nxt_op1 = burst_op_ff;
      end
      nxt_addr1 = {nxt_hi, burst_offset};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_ff       <= '0;
      burst_op_ff <= OP_RESET;
      op1_ff      <= OP_RESET;
      addr1_ff    <= '0;
      bw1_ff      <= '1;
    end else begin
      hi_ff       <= nxt_hi;
      burst_op_ff <= nxt_burst_op;
      op1_ff      <= nxt_op1;
      addr1_ff    <= nxt_addr1;
      bw1_ff      <= nxt_bw1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data stage: read output register, write data phase and bus direction.

  mem_port_if #(.ADDR_W(ADDR_W)) mport ();

  sram_array #(.ADDR_W(ADDR_W)) u_array (
    .clk  (clk),
    .port (mport.mem)
  );

  logic                wr2_ff;
  logic                nxt_wr2;
  logic [ADDR_W-1:0]   addr2_ff;
  logic [ADDR_W-1:0]   nxt_addr2;
  logic [LANES-1:0]    bw2_ff;
  logic [LANES-1:0]    nxt_bw2;
  logic                drive_ff;
  logic                nxt_drive;
  logic [WORD_W-1:0]   rdata_ff;
  logic [WORD_W-1:0]   nxt_rdata;
  logic [WORD_W-1:0]   wdata;
  logic [WORD_W-1:0]   fwd_data;
  logic                bus_drive;

  assign wdata = pack_word(dq_in, parity_lines_in);

  assign mport.rd_addr = addr1_ff;
  assign mport.wr_en   = step_en && wr2_ff;
  assign mport.wr_addr = addr2_ff;
  assign mport.wr_data = wdata;
  assign mport.wr_bw_n = bw2_ff;

  // A read right behind a write to the same word sees the new bytes.
  always_comb begin
    fwd_data = mport.rd_data;
    if (mport.wr_en && (addr2_ff == addr1_ff)) begin
      fwd_data = merge_lanes(mport.rd_data, wdata, bw2_ff);
    end
  end

  always_comb begin
    nxt_wr2   = wr2_ff;
    nxt_addr2 = addr2_ff;
    nxt_bw2   = bw2_ff;
    nxt_drive = drive_ff;
    nxt_rdata = rdata_ff;
    if (step_en) begin
      nxt_wr2   = (op1_ff == OP_WRITE);
      nxt_addr2 = addr1_ff;
      nxt_bw2   = bw1_ff;
      // Only a read beat drives; write data phases and deselects float.
      nxt_drive = (op1_ff == OP_READ);
      if (op1_ff == OP_READ) begin
        nxt_rdata = fwd_data;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr2_ff   <= 1'b0;
      addr2_ff <= '0;
      bw2_ff   <= '1;
      drive_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      wr2_ff   <= nxt_wr2;
      addr2_ff <= nxt_addr2;
      bw2_ff   <= nxt_bw2;
      drive_ff <= nxt_drive;
      rdata_ff <= nxt_rdata;
    end
  end

  // The enable pin is asynchronous, so it gates the drivers directly
  // rather than through a synchroniser that would add two cycles.
  assign bus_drive = drive_ff && !output_enable_n;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign dq_out[i*LANE_DW +: LANE_DW] = rdata_ff[i*LANE_W +: LANE_DW];
    assign parity_lines_out[i]          = rdata_ff[i*LANE_W + LANE_DW];
    assign dq_oe[i*LANE_DW +: LANE_DW]  = {LANE_DW{bus_drive}};
    assign parity_lines_oe[i]           = bus_drive;
  end

endmodule

// file: rtl/sram_array.sv
module sram_array
  import sram_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W
) (
  input wire logic clk,
  mem_port_if.mem  port
);

  if (ADDR_W < BURST_W + 1) begin : g_check
    $error("sram_array needs an address wider than the burst field");
  end

  logic [WORD_W-1:0] mem_ff [2**ADDR_W];

  // No reset: array contents are undefined at power-up, as in the real core.
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem_ff[port.wr_addr] <= merge_lanes(mem_ff[port.wr_addr], port.wr_data,
                                          port.wr_bw_n);
    end
  end

  assign port.rd_data = mem_ff[port.rd_addr];

endmodule

// file: rtl/sram_pkg.sv
package sram_pkg;

  localparam int LANES   = 4;
  localparam int LANE_DW = 8;
  localparam int LANE_W  = LANE_DW + 1;
  localparam int DATA_W  = LANES * LANE_DW;
  localparam int WORD_W  = LANES * LANE_W;
  localparam int BURST_W = 2;

  localparam int DEF_ADDR_W = 19;

  localparam logic MODE_INTERLEAVED = 1'b1;
  localparam logic MODE_LINEAR      = 1'b0;
  localparam logic MODE_RESET       = MODE_INTERLEAVED;

  localparam logic [BURST_W-1:0] BURST_CNT_RESET = 2'h0;
  localparam logic [BURST_W-1:0] BURST_CNT_STEP  = 2'h1;

  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b100
  } op_t;

  localparam op_t OP_RESET = OP_IDLE;

  // Each lane keeps its parity bit above its eight data bits.
  function automatic logic [WORD_W-1:0] pack_word(input logic [DATA_W-1:0] data,
                                                 input logic [LANES-1:0]  par);
    logic [WORD_W-1:0] w;
    w = '0;
    for (int i = 0; i < LANES; i++) begin
      w[i*LANE_W +: LANE_W] = {par[i], data[i*LANE_DW +: LANE_DW]};
    end
    return w;
  endfunction

  // Lanes whose active-low select is high keep the old contents.
  function automatic logic [WORD_W-1:0] merge_lanes(input logic [WORD_W-1:0] old_w,
                                                   input logic [WORD_W-1:0] new_w,
                                                   input logic [LANES-1:0]  bw_n);
    logic [WORD_W-1:0] w;
    w = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!bw_n[i]) begin
        w[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return w;
  endfunction

endpackage

// file: tb/mem_master_model.sv
module mem_master_model
  import sram_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              qual_n,
  input  wire logic              adv,
  input  wire logic              we_n,
  input  wire logic              sel,
  input  wire logic [WORD_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic [DATA_W-1:0] dq_oe,
  input  wire logic [LANES-1:0]  par_out,
  input  wire logic [LANES-1:0]  par_oe,
  output logic      [DATA_W-1:0] dq_in,
  output logic      [LANES-1:0]  par_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic              wr = 1'b0;
  logic              v0 = 1'b0;
  logic              v1 = 1'b0;
  logic [WORD_W-1:0] d0;
  logic [WORD_W-1:0] d1;
  logic [WORD_W-1:0] last = '0;
  logic [WORD_W-1:0] drv;
  // Write data goes out one qualified edge after the address beat, for one beat.
  always @(posedge clk) begin
    // Only a driven bus is remembered, so an unknown level before reset never sticks.
    if (v1 || dq_oe[0]) begin
      last <= {par_in, dq_in};
    end
    if (!qual_n) begin
      if (!adv) wr <= sel && !we_n;
      v0 <= adv ? wr : sel && !we_n;
      d0 <= wdata;
      v1 <= v0;
      d1 <= d0;
    end
  end
  // A released bus shows the inverse of its last level, so stale data never looks right.
  assign drv    = v1 ? d1 : ~last;
  assign dq_in  = (dq_oe & dq_out) | (~dq_oe & drv[DATA_W-1:0]);
  assign par_in = (par_oe & par_out) | (~par_oe & drv[WORD_W-1:DATA_W]);
endmodule

// file: tb/sram_ctl_monitor.sv
module sram_ctl_monitor
  import sram_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              chip_select_1_n,
  input wire logic              chip_select_2,
  input wire logic              chip_select_3_n,
  input wire logic              write_enable_n,
  input wire logic              advance_or_load,
  input wire logic              clock_qualify_n,
  input wire logic              output_enable_n,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic [DATA_W-1:0] dq_oe,
  input wire logic [LANES-1:0]  parity_lines_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ld;
  logic sel;
  assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign ld  = !clock_qualify_n && !advance_or_load;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  property p_oe_off; output_enable_n |-> dq_oe == '0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive with enable high");
  property p_lanes; parity_lines_oe == {LANES{dq_oe[0]}} && dq_oe == {DATA_W{dq_oe[0]}}; endproperty
  a_lanes: assert property (p_lanes) else $error("lanes differ in direction");
  property p_wr_float; ld && sel && !write_enable_n ##1 !clock_qualify_n |=> dq_oe == '0; endproperty
  a_wr_float: assert property (p_wr_float) else $error("drive in write data phase");
  property p_ds_float; ld && !sel ##1 !clock_qualify_n |=> parity_lines_oe == '0; endproperty
  a_ds_float: assert property (p_ds_float) else $error("drive while deselected");
  property p_fresh; ld && !sel ##1 ld && sel && write_enable_n |=> dq_oe == '0; endproperty
  a_fresh: assert property (p_fresh) else $error("drive right after deselect");
  property p_rd_drive;
    ld && sel && write_enable_n ##1 !clock_qualify_n |=> output_enable_n || dq_oe == '1;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read answer not driven");
  property p_hold_data; clock_qualify_n |=> $stable(dq_out); endproperty
  a_hold_data: assert property (p_hold_data) else $error("data moved when masked");
  property p_hold_oe; clock_qualify_n ##1 $stable(output_enable_n) |-> $stable(dq_oe); endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("direction moved when masked");
  c_stall: cover property (clock_qualify_n [*3]);
  c_burst: cover property (ld && sel ##1 !clock_qualify_n && advance_or_load);
  c_wr_rd: cover property (ld && !write_enable_n ##1 ld && write_enable_n);
endmodule

bind pipelined_sram_io_control sram_ctl_monitor mon (.*);

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sram_pkg::*;
  localparam int AW = 4;
  logic clk = 0, rst = 1, chip_select_1_n = 1, chip_select_2 = 0, chip_select_3_n = 1;
  logic write_enable_n = 1, advance_or_load = 0, clock_qualify_n = 0, output_enable_n = 0;
  logic burst_mode = 1;
  logic [AW-1:0]     addr = '0, ba = '0, ea;
  logic [LANES-1:0]  byte_write_select_n = '1, parity_lines_in, parity_lines_out, parity_lines_oe;
  logic [DATA_W-1:0] dq_in, dq_out, dq_oe;
  logic [WORD_W-1:0] wd = '0, pend, mem [16];
  int                miscompares = 0, n_checks = 0, cyc = 0, pk = 2, bk = 2, cnt = 0;
  always #25 clk = ~clk;
  pipelined_sram_io_control #(.ADDR_W(AW)) DUT (.*);
  mem_master_model ctl (
    .clk    (clk),
    .qual_n (clock_qualify_n),
    .adv    (advance_or_load),
    .we_n   (write_enable_n),
    .sel    (!chip_select_1_n && chip_select_2 && !chip_select_3_n),
    .wdata  (wd),
    .dq_out (dq_out),
    .dq_oe  (dq_oe),
    .par_out(parity_lines_out),
    .par_oe (parity_lines_oe),
    .dq_in  (dq_in),
    .par_in (parity_lines_in)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // k: 0 read load, 1 write load, 2 deselect, 3 advance with selects and write ignored.
  // A deselect drops the select named by a[1:0]: 0 the second, 1 the first, 2 the third.
  task automatic op(input int k, input logic [AW-1:0] a, input logic [WORD_W-1:0] d,
                    input logic [LANES-1:0] bw);
    advance_or_load = (k == 3);
    chip_select_1_n = (k == 3) || (k == 2 && a[1:0] == 2'h1);
    chip_select_2 = !(k == 2 && a[1:0] == 2'h0);
    chip_select_3_n = (k == 3) || (k == 2 && a[1:0] == 2'h2);
    write_enable_n = (k == 0);
    addr = a;
    wd = d;
    byte_write_select_n = bw;
    if (k < 3) begin
      ba = a;
      cnt = 0;
      bk = k;
    end else cnt++;
    ea = {ba[AW-1:2], burst_mode ? ba[1:0] ^ 2'(cnt) : ba[1:0] + 2'(cnt)};
    if (bk == 1) for (int i = 0; i < LANES; i++) if (!bw[i]) begin
      mem[ea][8*i +: 8] = d[8*i +: 8];
      mem[ea][DATA_W+i] = d[DATA_W+i];
    end
    @(posedge clk);
    #2;
    if (pk == 0) chk({parity_lines_out, dq_out}, pend);
    chk({parity_lines_oe, dq_oe}, pk == 0 ? '1 : '0);
    pk = bk;
    pend = mem[ea];
  endtask
  // The strap only moves while reset is held.
  task automatic do_reset(input logic m);
    burst_mode = m;
    rst = 1;
    repeat (4) @(posedge clk);
    #2;
    rst = 0;
    pk = 2;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_rw();
    op(1, 4'h3, 36'h9_a1b2c3d4, 4'h0);
    op(1, 4'h3, 36'h6_55667788, 4'ha);
    op(0, 4'h3, '0, '1);
    op(1, 4'h5, 36'hf_0badcafe, 4'h0);
    op(0, 4'h5, '0, '1);
    op(2, '0, '0, '1);
    op(2, 4'h1, '0, '1);
  endtask
  // The masked edges offer a write that must not be taken.
  task automatic t_oe_stall();
    op(0, 4'h3, '0, '1);
    op(0, 4'h5, '0, '1);
    output_enable_n = 1;
    clock_qualify_n = 1;
    write_enable_n = 0;
    byte_write_select_n = '0;
    #1 chk({parity_lines_oe, dq_oe}, '0);
    @(posedge clk);
    #2;
    output_enable_n = 0;
    #1 chk({parity_lines_oe, dq_oe}, '1);
    repeat (2) @(posedge clk);
    #2;
    chk({parity_lines_out, dq_out}, mem[3]);
    chk({parity_lines_oe, dq_oe}, '1);
    clock_qualify_n = 0;
    op(2, 4'h2, '0, '1);
    op(0, 4'h5, '0, '1);
    op(2, '0, '0, '1);
    op(3, '0, '0, '1);
    op(2, 4'h1, '0, '1);
  endtask
  task automatic t_burst(input logic m);
    do_reset(m);
    for (int i = 0; i < 4; i++) op(1, 4'h8 + 4'(i), {4'(i), 32'h5a5a0000 + 32'(i)}, '0);
    for (int i = 0; i < 5; i++) op(i ? 3 : 0, 4'h9, '0, '1);
    for (int i = 0; i < 4; i++) op(i ? 3 : 1, 4'he, {4'(~i), 32'hc3c30000 + 32'(i)}, '0);
    for (int i = 0; i < 4; i++) op(0, 4'hc + 4'(i), '0, '1);
    op(2, '0, '0, '1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    do_reset(1'b1);
    t_rw();
    t_oe_stall();
    t_burst(1'b0);
    t_burst(1'b1);
    conclude();
  end
endmodule
